// ==== hw/sync_source_coast_clamp_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Horizontal override bit forces select-bit source
// - Select: 0 dedicated pin, 1 sync-on-green
// - Vertical output inverted at 0, passed at 1
// - Vertical override bit forces select-bit source
// - Vertical select: 0 pin, 1 separator
// - Clamp source: 0 internal counts, 1 pin
// - External clamp holds while pin active
// - Clamp polarity 1 active low, 0 high
// - Coast source: 0 pin, 1 selected vsync
// - Coast polarity override picks user polarity
// - Hold active at polarity bit level, freezes clock
// - Seek mode when allowed and no sync
// - Power-down bit 0 powers down, resets 1
// - Power-down floats sync, clock, data outputs
// - Sync logic and registers run in power-down
// - Slicer threshold five bits, resets to 15
// - Red clamp target ground or midscale
// - Blue clamp target ground or midscale
// - Separator toggles after programmed 5 MHz periods
// - With vsync as coast source, hold starts programmed lines before vsync
// - With vsync as coast source, hold extends programmed lines after vsync
// - Auto horizontal picks the lone active source
// - Auto vertical uses pin when active
// - Internal clamp delayed then lasts programmed periods
module sync_source_coast_clamp_ctrl (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       reg_we_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       hsync_pin_i,
  input  wire logic       sog_pin_i,
  input  wire logic       vsync_pin_i,
  input  wire logic       coast_pin_i,
  input  wire logic       clamp_pin_i,
  input  wire logic       hsync_activity_i,
  input  wire logic       sog_activity_i,
  input  wire logic       vsync_activity_i,
  input  wire logic       coast_pol_detected_i,
  output logic            horizontal_sync_output_o,
  output logic            vertical_sync_output_o,
  output logic            green_sync_output_o,
  output logic            outputs_oe_n_o,
  output logic            power_down_o,
  output logic            seek_mode_o,
  output logic            coast_hold_o,
  output logic            clamp_o,
  output logic            active_horizontal_source_o,
  output logic            active_vertical_source_o,
  output logic      [4:0] slicer_threshold_o,
  output logic            red_midscale_o,
  output logic            blue_midscale_o
);
  logic [7:0] clamp_place_reg, clamp_dur_reg, sync_src_reg, clamp_coast_reg;
  logic [7:0] slicer_reg, sep_count_reg, hold_lead_reg, hold_trail_reg;
  localparam int PIN_COUNT_W = sync_ctrl_pkg::PIN_COUNT;
  logic [PIN_COUNT_W-1:0] pin_meta_reg, pin_sync_reg;

  sync_ctrl_pkg::sync_src_s    src_ctl;
  sync_ctrl_pkg::clamp_coast_s cc_ctl;
  assign src_ctl = sync_ctrl_pkg::sync_src_s'(sync_src_reg);
  assign cc_ctl  = sync_ctrl_pkg::clamp_coast_s'(clamp_coast_reg);

  // Register port stays live in power-down so software can wake the part
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clamp_place_reg <= sync_ctrl_pkg::CLAMP_PLACE_RST;
      clamp_dur_reg   <= sync_ctrl_pkg::CLAMP_DUR_RST;
      sync_src_reg    <= sync_ctrl_pkg::SYNC_SRC_RST;
      clamp_coast_reg <= sync_ctrl_pkg::CLAMP_COAST_RST;
      slicer_reg      <= sync_ctrl_pkg::SLICER_RST;
      sep_count_reg   <= sync_ctrl_pkg::SEP_COUNT_RST;
      hold_lead_reg   <= sync_ctrl_pkg::HOLD_LEAD_RST;
      hold_trail_reg  <= sync_ctrl_pkg::HOLD_TRAIL_RST;
    end else if (reg_we_i) begin
      if (hit(reg_addr_i, sync_ctrl_pkg::CLAMP_PLACE_ADDR)) clamp_place_reg <= reg_wdata_i;
      if (hit(reg_addr_i, sync_ctrl_pkg::CLAMP_DUR_ADDR))   clamp_dur_reg   <= reg_wdata_i;
      if (hit(reg_addr_i, sync_ctrl_pkg::SYNC_SRC_ADDR))    sync_src_reg    <= reg_wdata_i;
      if (hit(reg_addr_i, sync_ctrl_pkg::CLAMP_COAST_ADDR)) clamp_coast_reg <= reg_wdata_i;
      if (hit(reg_addr_i, sync_ctrl_pkg::SLICER_ADDR))      slicer_reg      <= {reg_wdata_i[7:1], 1'b0};
      if (hit(reg_addr_i, sync_ctrl_pkg::SEP_COUNT_ADDR))   sep_count_reg   <= reg_wdata_i;
      if (hit(reg_addr_i, sync_ctrl_pkg::HOLD_LEAD_ADDR))   hold_lead_reg   <= reg_wdata_i;
      if (hit(reg_addr_i, sync_ctrl_pkg::HOLD_TRAIL_ADDR))  hold_trail_reg  <= reg_wdata_i;
    end
  end

  // Two-stage synchronisers for every pin input
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT_W; gi++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= (gi == sync_ctrl_pkg::PIN_HS)    ? hsync_pin_i :
                              (gi == sync_ctrl_pkg::PIN_SOG)   ? sog_pin_i :
                              (gi == sync_ctrl_pkg::PIN_VS)    ? vsync_pin_i :
                              (gi == sync_ctrl_pkg::PIN_COAST) ? coast_pin_i : clamp_pin_i;
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  wire hs_s    = pin_sync_reg[sync_ctrl_pkg::PIN_HS];
  wire sog_s   = pin_sync_reg[sync_ctrl_pkg::PIN_SOG];
  wire vs_s    = pin_sync_reg[sync_ctrl_pkg::PIN_VS];
  wire coast_s = pin_sync_reg[sync_ctrl_pkg::PIN_COAST];
  wire clamp_s = pin_sync_reg[sync_ctrl_pkg::PIN_CLAMP];

  // Horizontal source choice
  wire hs_only   = hsync_activity_i & ~sog_activity_i;
  wire sog_only  = sog_activity_i & ~hsync_activity_i;
  wire ahs_auto  = sog_only ? 1'b1 : (hs_only ? 1'b0 : src_ctl.hs_sel);
  wire ahs_next  = src_ctl.hs_ovr ? src_ctl.hs_sel : ahs_auto;
  wire hs_sel_s  = ahs_next ? sog_s : hs_s;

  // Sync separator on a 5 MHz enable
  logic [5:0] sep_div_reg;
  logic [7:0] sep_cnt_reg;
  logic       sep_out_reg;
  wire        sep_tick  = (sep_div_reg == sync_ctrl_pkg::SEP_DIV);
  wire [8:0]  sep_cnt_1 = {1'b0, sep_cnt_reg} + 9'h001;
  wire        sep_fire  = sep_tick & (hs_sel_s != sep_out_reg) & (sep_cnt_1 >= {1'b0, sep_count_reg});

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sep_div_reg <= 6'h00;
      sep_cnt_reg <= 8'h00;
      sep_out_reg <= 1'b0;
    end else begin
      sep_div_reg <= sep_tick ? 6'h00 : sep_div_reg + 6'h01;
      if (hs_sel_s == sep_out_reg) begin
        sep_cnt_reg <= 8'h00;
      end else if (sep_fire) begin
        sep_cnt_reg <= 8'h00;
        sep_out_reg <= ~sep_out_reg;
      end else if (sep_tick) begin
        sep_cnt_reg <= sep_cnt_1[7:0];
      end
    end
  end

  // Vertical source choice
  wire avs_auto  = ~vsync_activity_i;
  wire avs_next  = src_ctl.vs_ovr ? src_ctl.vs_sel : avs_auto;
  wire vs_src    = avs_next ? sep_out_reg : vs_s;
  wire vs_out    = src_ctl.vs_no_invert ? vs_src : ~vs_src;

  // Edge pulses of the selected syncs, taken as active high
  logic hs_d_reg, vs_d_reg;
  wire  hs_lead  = hs_sel_s & ~hs_d_reg;
  wire  hs_trail = ~hs_sel_s & hs_d_reg;
  wire  vs_lead  = vs_src & ~vs_d_reg;
  wire  vs_trail = ~vs_src & vs_d_reg;

  // Lines per frame learnt from the previous frame, so pre-hold can anticipate vsync
  logic [11:0] line_cnt_reg, frame_len_reg;
  logic [7:0]  post_cnt_reg;
  wire  [12:0] lead_sum  = {1'b0, line_cnt_reg} + {5'h00, hold_lead_reg};
  wire         pre_hold  = (hold_lead_reg != 8'h00) & (frame_len_reg != 12'h000) &
                           (lead_sum >= {1'b0, frame_len_reg});
  wire         post_hold = (post_cnt_reg != 8'h00);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hs_d_reg      <= 1'b0;
      vs_d_reg      <= 1'b0;
      line_cnt_reg  <= 12'h000;
      frame_len_reg <= 12'h000;
      post_cnt_reg  <= 8'h00;
    end else begin
      hs_d_reg <= hs_sel_s;
      vs_d_reg <= vs_src;
      if (vs_lead) begin
        line_cnt_reg  <= 12'h000;
        frame_len_reg <= line_cnt_reg;
      end else if (hs_lead && line_cnt_reg != 12'hfff) begin
        line_cnt_reg <= line_cnt_reg + 12'h001;
      end
      if (vs_trail) begin
        post_cnt_reg <= hold_trail_reg;
      end else if (hs_lead && post_hold) begin
        post_cnt_reg <= post_cnt_reg - 8'h01;
      end
    end
  end

  // Hold (coast) generation
  wire coast_raw  = cc_ctl.coast_src ? vs_src : coast_s;
  wire coast_pol  = cc_ctl.coast_pol_ovr ? cc_ctl.hold_polarity_bit : coast_pol_detected_i;
  wire hold_base  = (coast_raw == coast_pol);
  wire post_start = vs_trail & (hold_trail_reg != 8'h00);
  wire hold_next  = hold_base | (cc_ctl.coast_src & (pre_hold | post_hold | post_start));

  // Internal clamp sequencer counted from the hsync trailing edge
  sync_ctrl_pkg::clamp_state_e clamp_st_reg, clamp_st_next;
  logic [7:0] clamp_cnt_reg, clamp_cnt_next;
  wire        cnt_last = (clamp_cnt_reg <= 8'h01);

  always_comb begin
    clamp_st_next  = clamp_st_reg;
    clamp_cnt_next = clamp_cnt_reg;
    case (clamp_st_reg)
      sync_ctrl_pkg::CLAMP_IDLE: begin
        if (hs_trail) begin
          clamp_st_next  = sync_ctrl_pkg::CLAMP_WAIT;
          clamp_cnt_next = clamp_place_reg;
        end
      end
      sync_ctrl_pkg::CLAMP_WAIT: begin
        clamp_cnt_next = clamp_cnt_reg - 8'h01;
        if (cnt_last) begin
          clamp_st_next  = sync_ctrl_pkg::CLAMP_ON;
          clamp_cnt_next = clamp_dur_reg;
        end
      end
      sync_ctrl_pkg::CLAMP_ON: begin
        clamp_cnt_next = clamp_cnt_reg - 8'h01;
        if (cnt_last) begin
          clamp_st_next = sync_ctrl_pkg::CLAMP_IDLE;
        end
      end
      default: begin
        clamp_st_next  = sync_ctrl_pkg::CLAMP_IDLE;
        clamp_cnt_next = 8'h00;
      end
    endcase
  end

  wire ext_clamp  = clamp_s ^ cc_ctl.clamp_pol;
  wire clamp_next = cc_ctl.clamp_ext ? ext_clamp : (clamp_st_reg == sync_ctrl_pkg::CLAMP_ON);
  wire no_sync    = ~(hsync_activity_i | sog_activity_i | vsync_activity_i);

  // Read mux, status at its own offset, unmapped reads zero
  logic [7:0] rdata_next;
  always_comb begin
    case (reg_addr_i)
      sync_ctrl_pkg::CLAMP_PLACE_ADDR:  rdata_next = clamp_place_reg;
      sync_ctrl_pkg::CLAMP_DUR_ADDR:    rdata_next = clamp_dur_reg;
      sync_ctrl_pkg::SYNC_SRC_ADDR:     rdata_next = sync_src_reg;
      sync_ctrl_pkg::CLAMP_COAST_ADDR:  rdata_next = clamp_coast_reg;
      sync_ctrl_pkg::SLICER_ADDR:       rdata_next = slicer_reg;
      sync_ctrl_pkg::SEP_COUNT_ADDR:    rdata_next = sep_count_reg;
      sync_ctrl_pkg::HOLD_LEAD_ADDR:    rdata_next = hold_lead_reg;
      sync_ctrl_pkg::HOLD_TRAIL_ADDR:   rdata_next = hold_trail_reg;
      sync_ctrl_pkg::SYNC_STATUS_ADDR:  rdata_next = {hsync_activity_i, active_horizontal_source_o, 1'b0,
                                                      vsync_activity_i, active_vertical_source_o, 1'b0,
                                                      sog_activity_i, 1'b0};
      default:                          rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clamp_st_reg               <= sync_ctrl_pkg::CLAMP_IDLE;
      clamp_cnt_reg              <= 8'h00;
      reg_rdata_o                <= 8'h00;
      horizontal_sync_output_o   <= 1'b0;
      vertical_sync_output_o     <= 1'b0;
      green_sync_output_o        <= 1'b0;
      outputs_oe_n_o             <= 1'b0;
      power_down_o               <= 1'b0;
      seek_mode_o                <= 1'b0;
      coast_hold_o               <= 1'b0;
      clamp_o                    <= 1'b0;
      active_horizontal_source_o <= 1'b0;
      active_vertical_source_o   <= 1'b0;
    end else begin
      clamp_st_reg               <= clamp_st_next;
      clamp_cnt_reg              <= clamp_cnt_next;
      reg_rdata_o                <= rdata_next;
      horizontal_sync_output_o   <= hs_sel_s;
      vertical_sync_output_o     <= vs_out;
      green_sync_output_o        <= sog_s;
      outputs_oe_n_o             <= ~cc_ctl.power_down_bit;
      power_down_o               <= ~cc_ctl.power_down_bit;
      seek_mode_o                <= cc_ctl.seek_allow & no_sync;
      coast_hold_o               <= hold_next;
      clamp_o                    <= clamp_next;
      active_horizontal_source_o <= ahs_next;
      active_vertical_source_o   <= avs_next;
    end
  end

  assign slicer_threshold_o = slicer_reg[7:3];
  assign red_midscale_o     = slicer_reg[2];
  assign blue_midscale_o    = slicer_reg[1];

  a_reset_values: assert property (@(posedge mclk_i) reset_i |=>
    (slicer_reg == 8'h78) && (sep_count_reg == 8'h20) && (clamp_coast_reg == 8'h4e) && (sync_src_reg == 8'h40))
    else $error("register reset values wrong");
  a_hsel_override: assert property (@(posedge mclk_i) disable iff (reset_i)
    src_ctl.hs_ovr |=> (active_horizontal_source_o == $past(src_ctl.hs_sel)))
    else $error("horizontal override not obeyed");
  a_hsel_auto: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!src_ctl.hs_ovr && sog_only) |=> active_horizontal_source_o)
    else $error("lone green sync not chosen");
  a_vsel_auto: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!src_ctl.vs_ovr && vsync_activity_i) |=> !active_vertical_source_o)
    else $error("active vsync pin not chosen");
  a_ext_clamp_on: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cc_ctl.clamp_ext && cc_ctl.clamp_pol && !clamp_s) |=> clamp_o)
    else $error("active low clamp pin not followed");
  a_int_clamp_start: assert property (@(posedge mclk_i) disable iff (reset_i)
    (clamp_st_reg == sync_ctrl_pkg::CLAMP_WAIT && cnt_last) |=> (clamp_st_reg == sync_ctrl_pkg::CLAMP_ON))
    else $error("internal clamp did not start");
  a_int_clamp_drive: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!cc_ctl.clamp_ext && clamp_st_reg == sync_ctrl_pkg::CLAMP_IDLE) |=> !clamp_o)
    else $error("clamp active while sequencer idle");
  a_power_float: assert property (@(posedge mclk_i) disable iff (reset_i)
    !cc_ctl.power_down_bit |=> (outputs_oe_n_o && power_down_o))
    else $error("outputs driven in power-down");
  a_seek_entry: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!cc_ctl.seek_allow) |=> !seek_mode_o)
    else $error("seek entered while disallowed");
  a_sep_toggle: assert property (@(posedge mclk_i) disable iff (reset_i)
    sep_fire |=> (sep_out_reg != $past(sep_out_reg)) ##1 (sep_out_reg == $past(sep_out_reg)))
    else $error("separator toggle wrong");
  a_post_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cc_ctl.coast_src && post_hold) |=> coast_hold_o)
    else $error("post hold missing");

  c_int_clamp: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(clamp_o) && !cc_ctl.clamp_ext);
  c_sep_toggle: cover property (@(posedge mclk_i) disable iff (reset_i) sep_fire);
  c_pre_hold: cover property (@(posedge mclk_i) disable iff (reset_i) pre_hold && cc_ctl.coast_src);
endmodule

// ==== shared/sync_ctrl_pkg.sv ====
package sync_ctrl_pkg;
  // Register offsets
  localparam logic [7:0] CLAMP_PLACE_ADDR  = 8'h05;
  localparam logic [7:0] CLAMP_DUR_ADDR    = 8'h06;
  localparam logic [7:0] SYNC_SRC_ADDR     = 8'h0e;
  localparam logic [7:0] CLAMP_COAST_ADDR  = 8'h0f;
  localparam logic [7:0] SLICER_ADDR       = 8'h10;
  localparam logic [7:0] SEP_COUNT_ADDR    = 8'h11;
  localparam logic [7:0] HOLD_LEAD_ADDR    = 8'h12;
  localparam logic [7:0] HOLD_TRAIL_ADDR   = 8'h13;
  localparam logic [7:0] SYNC_STATUS_ADDR  = 8'h14;

  // Values after reset
  localparam logic [7:0] CLAMP_PLACE_RST   = 8'h08;
  localparam logic [7:0] CLAMP_DUR_RST     = 8'h14;
  localparam logic [7:0] SYNC_SRC_RST      = 8'h40;
  localparam logic [7:0] CLAMP_COAST_RST   = 8'h4e;
  localparam logic [7:0] SLICER_RST        = 8'h78;
  localparam logic [7:0] SEP_COUNT_RST     = 8'h20;
  localparam logic [7:0] HOLD_LEAD_RST     = 8'h00;
  localparam logic [7:0] HOLD_TRAIL_RST    = 8'h00;

  // Separator tick derived from the pixel clock
  localparam int         MCLK_HZ           = 250000000;
  localparam int         SEP_CLK_HZ        = 5000000;
  localparam int         SEP_DIV_INT       = MCLK_HZ / SEP_CLK_HZ;
  localparam logic [5:0] SEP_DIV           = 6'(SEP_DIV_INT - 1);

  // Sync pin indices in the synchroniser vector
  localparam int         PIN_HS            = 0;
  localparam int         PIN_SOG           = 1;
  localparam int         PIN_VS            = 2;
  localparam int         PIN_COAST         = 3;
  localparam int         PIN_CLAMP         = 4;
  localparam int         PIN_COUNT         = 5;

  typedef struct packed {
    logic hs_pol_ovr;
    logic hs_pol;
    logic hs_out_pol;
    logic hs_ovr;
    logic hs_sel;
    logic vs_no_invert;
    logic vs_ovr;
    logic vs_sel;
  } sync_src_s;

  typedef struct packed {
    logic clamp_ext;
    logic clamp_pol;
    logic coast_src;
    logic coast_pol_ovr;
    logic hold_polarity_bit;
    logic seek_allow;
    logic power_down_bit;
    logic spare;
  } clamp_coast_s;

  typedef enum logic [1:0] {
    CLAMP_IDLE = 2'b00,
    CLAMP_WAIT = 2'b01,
    CLAMP_ON   = 2'b11
  } clamp_state_e;
endpackage

// ==== dv/video_source_model.sv ====
`timescale 1ns/1ps
// Graphics source: periodic horizontal pulses on the sync pin or on green,
// and a vertical pulse every few lines on the vertical pin.
module video_source_model #(
  parameter int LINE_CLKS   = 40,
  parameter int PULSE_CLKS  = 4,  // Far below the separator count
  parameter int FRAME_LINES = 10
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic hs_en_i,
  input  wire logic sog_en_i,
  input  wire logic vs_en_i,
  output logic      hsync_pin_o,
  output logic      sog_pin_o,
  output logic      vsync_pin_o,
  output logic      hsync_activity_o,
  output logic      sog_activity_o,
  output logic      vsync_activity_o
);
  int  pix;
  int  line;
  // Counters move on the falling edge so pins never change at the sampling edge
  always @(negedge mclk_i) begin
    if (reset_i || pix == LINE_CLKS - 1) begin
      pix <= 0;
    end else begin
      pix <= pix + 1;
    end
    if (reset_i) begin
      line <= 0;
    end else if (pix == LINE_CLKS - 1) begin
      line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
    end
  end
  // A silent source parks its pin low and drops its activity flag, which follows the enable
  assign hsync_pin_o      = hs_en_i && pix < PULSE_CLKS;
  assign sog_pin_o        = sog_en_i && pix < PULSE_CLKS;
  assign vsync_pin_o      = vs_en_i && line < 2;
  assign hsync_activity_o = hs_en_i;
  assign sog_activity_o   = sog_en_i;
  assign vsync_activity_o = vs_en_i;
endmodule

// ==== dv/sync_source_coast_clamp_ctrl_bench.sv ====
`timescale 1ns/1ps
module sync_source_coast_clamp_ctrl_bench;
  logic       mclk_i, reset_i, reg_we_i, coast_pin_i, clamp_pin_i, coast_pol_detected_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic       hs_en, sog_en, vs_en, hs_pin, sog_pin, vs_pin, hs_act, sog_act, vs_act;
  logic       hs_out, vs_out, sog_out, oe_n, pd, seek, hold, clamp, active_horizontal_source, active_vertical_source, red_mid, blue_mid;
  logic [4:0] slicer;
  int         n_mismatch;
  int         num_checks;

  sync_source_coast_clamp_ctrl u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .hsync_pin_i(hs_pin), .sog_pin_i(sog_pin),
    .vsync_pin_i(vs_pin), .coast_pin_i(coast_pin_i), .clamp_pin_i(clamp_pin_i), .hsync_activity_i(hs_act),
    .sog_activity_i(sog_act), .vsync_activity_i(vs_act), .coast_pol_detected_i(coast_pol_detected_i),
    .horizontal_sync_output_o(hs_out), .vertical_sync_output_o(vs_out), .green_sync_output_o(sog_out),
    .outputs_oe_n_o(oe_n), .power_down_o(pd), .seek_mode_o(seek), .coast_hold_o(hold), .clamp_o(clamp),
    .active_horizontal_source_o(active_horizontal_source), .active_vertical_source_o(active_vertical_source), .slicer_threshold_o(slicer),
    .red_midscale_o(red_mid), .blue_midscale_o(blue_mid));

  video_source_model u_src (
    .mclk_i(mclk_i), .reset_i(reset_i), .hs_en_i(hs_en), .sog_en_i(sog_en), .vs_en_i(vs_en),
    .hsync_pin_o(hs_pin), .sog_pin_o(sog_pin), .vsync_pin_o(vs_pin), .hsync_activity_o(hs_act),
    .sog_activity_o(sog_act), .vsync_activity_o(vs_act));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_we_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_we_i = 1'b0;
  endtask

  // Read data is registered: it belongs to the address of the previous cycle
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    reg_addr_i = a;
    @(negedge mclk_i);
    chk(what, exp, reg_rdata_o);
  endtask

  // Pin to output takes three edges; four leaves a margin
  task automatic settle();
    repeat (4) @(negedge mclk_i);
  endtask

  // Unknown levels count as low so they cannot slip through as a pass
  task automatic count_high(input int n, input logic pick_hs, output int hi_clamp, output int hi_sync);
    hi_clamp = 0;
    hi_sync = 0;
    repeat (n) begin
      @(negedge mclk_i);
      hi_clamp += (clamp === 1'b1) ? 1 : 0;
      hi_sync += ((pick_hs ? hs_out : sog_out) === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic t_reset();
    rd_chk("sync_source_control", sync_ctrl_pkg::SYNC_SRC_ADDR, 8'h40);
    rd_chk("clamp_coast_power", sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4e);
    rd_chk("slicer_and_target", sync_ctrl_pkg::SLICER_ADDR, 8'h78);
    rd_chk("separator_count", sync_ctrl_pkg::SEP_COUNT_ADDR, 8'h20);
    rd_chk("hold_lead_count", sync_ctrl_pkg::HOLD_LEAD_ADDR, 8'h00);
    rd_chk("hold_trail_count", sync_ctrl_pkg::HOLD_TRAIL_ADDR, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    chk("slicer_threshold", 8'h0f, {3'b000, slicer});
    chk("power_down", 8'h00, {7'b0, pd});
    wr(sync_ctrl_pkg::SLICER_ADDR, 8'haf);
    rd_chk("slicer_written", sync_ctrl_pkg::SLICER_ADDR, 8'hae);
    chk("slicer_field", 8'h15, {3'b000, slicer});
    chk("midscale_pair", 8'h03, {6'b0, red_mid, blue_mid});
    wr(sync_ctrl_pkg::SLICER_ADDR, 8'h78);
    chk("midscale_off", 8'h00, {6'b0, red_mid, blue_mid});
    $display("test reset_values done");
  endtask

  task automatic t_hsync();
    logic e;
    for (int i = 0; i < 16; i++) begin
      hs_en = i[1];
      sog_en = i[0];
      wr(sync_ctrl_pkg::SYNC_SRC_ADDR, {3'b010, i[3], i[2], 3'b000});
      settle();
      e = i[3] ? i[2] : (i[1] && !i[0]) ? 1'b0 : (!i[1] && i[0]) ? 1'b1 : i[2];
      chk("active_horizontal_source", {7'b0, e}, {7'b0, active_horizontal_source});
    end
    $display("test horizontal_select done");
  endtask

  task automatic t_vsync();
    for (int i = 0; i < 8; i++) begin
      vs_en = i[0];
      wr(sync_ctrl_pkg::SYNC_SRC_ADDR, {6'b010000, i[2], i[1]});
      settle();
      chk("active_vertical_source", {7'b0, i[2] ? i[1] : !i[0]}, {7'b0, active_vertical_source});
    end
    vs_en = 1'b0;
    wr(sync_ctrl_pkg::SYNC_SRC_ADDR, 8'h42);
    settle();
    chk("vsync_inverted", 8'h01, {7'b0, vs_out});
    wr(sync_ctrl_pkg::SYNC_SRC_ADDR, 8'h46);
    settle();
    chk("vsync_passed", 8'h00, {7'b0, vs_out});
    // Narrow hsync pulses on the separator input must not reach the vertical path
    wr(sync_ctrl_pkg::SYNC_SRC_ADDR, 8'h47);
    settle();
    chk("separator_filters_hsync", 8'h00, {7'b0, vs_out});
    $display("test vertical_select done");
  endtask

  task automatic t_coast();
    logic eff;
    for (int i = 0; i < 16; i++) begin
      wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, {3'b010, i[3], i[2], 3'b110});
      coast_pol_detected_i = i[1];
      coast_pin_i = i[0];
      settle();
      eff = i[3] ? i[2] : i[1];
      chk("coast_hold", {7'b0, i[0] == eff}, {7'b0, hold});
    end
    // Coast pin is left high here, so a hold taken from the pin would show the opposite level
    vs_en = 1'b0;
    wr(sync_ctrl_pkg::SYNC_SRC_ADDR, 8'h42);
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h76);
    settle();
    chk("coast_from_vsync_low", 8'h01, {7'b0, hold});
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h7e);
    settle();
    chk("coast_from_vsync_high", 8'h00, {7'b0, hold});
    // Two lines of post hold: held well inside them, released well past them
    wr(sync_ctrl_pkg::HOLD_TRAIL_ADDR, 8'h02);
    vs_en = 1'b1;
    @(negedge vs_pin);
    repeat (60) @(negedge mclk_i);
    chk("post_hold_inside", 8'h01, {7'b0, hold});
    repeat (40) @(negedge mclk_i);
    chk("post_hold_past", 8'h00, {7'b0, hold});
    vs_en = 1'b0;
    wr(sync_ctrl_pkg::HOLD_TRAIL_ADDR, 8'h00);
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4e);
    $display("test coast_hold done");
  endtask

  task automatic t_clamp();
    int hc;
    int hs;
    for (int i = 0; i < 4; i++) begin
      wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, {1'b1, i[1], 6'b001110});
      clamp_pin_i = i[0];
      settle();
      chk("external_clamp", {7'b0, i[1] ? !i[0] : i[0]}, {7'b0, clamp});
    end
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4e);
    wr(sync_ctrl_pkg::SYNC_SRC_ADDR, 8'h50);
    wr(sync_ctrl_pkg::CLAMP_DUR_ADDR, 8'h05);
    hs_en = 1'b1;
    count_high(80, 1'b1, hc, hs);
    // Two whole lines hold exactly two clamp windows whatever the phase
    count_high(80, 1'b1, hc, hs);
    chk("internal_clamp_cycles", 8'h0a, 8'(hc));
    chk("horizontal_sync_output", 8'h08, 8'(hs));
    $display("test clamp done");
  endtask

  task automatic t_power();
    int hc;
    int hs;
    hs_en = 1'b0;
    sog_en = 1'b0;
    vs_en = 1'b0;
    settle();
    chk("seek_allowed", 8'h01, {7'b0, seek});
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4a);
    settle();
    chk("seek_blocked", 8'h00, {7'b0, seek});
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4e);
    hs_en = 1'b1;
    settle();
    chk("seek_with_sync", 8'h00, {7'b0, seek});
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4c);
    sog_en = 1'b1;
    settle();
    chk("power_down_float", 8'h03, {6'b0, pd, oe_n});
    count_high(40, 1'b0, hc, hs);
    chk("green_sync_driven", 8'h04, 8'(hs));
    wr(sync_ctrl_pkg::HOLD_LEAD_ADDR, 8'h33);
    rd_chk("register_in_power_down", sync_ctrl_pkg::HOLD_LEAD_ADDR, 8'h33);
    wr(sync_ctrl_pkg::CLAMP_COAST_ADDR, 8'h4e);
    settle();
    chk("power_restored", 8'h00, {6'b0, pd, oe_n});
    $display("test power done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; this 50000-cycle limit allows over fifty times more
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    {reset_i, reg_we_i, coast_pin_i, clamp_pin_i, coast_pol_detected_i} = 5'b10000;
    {hs_en, sog_en, vs_en} = 3'b000;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    n_mismatch = 0;
    num_checks = 0;
    repeat (6) @(negedge mclk_i);
    reset_i = 1'b0;
    t_reset();
    t_hsync();
    t_vsync();
    t_coast();
    t_clamp();
    t_power();
    stop_test();
  end
endmodule
